//--- design/dgpio_pkg.sv
// constants for the dual port pin multiplexer
// Function
// - first port input pin is Schmitt input, pull-up on when enabled.
// - external bus drives and samples upper first-port pins on largest package only, ignoring direction.
// - external bus beats every other function on those pins.
// - PWM1 channels C and B drive pins at direction 0, tristate on shutdown.
// - capture unit drives top pin at direction 0, captures at 1.
// - PWM1 channels reach these pins only with PWM remap set.
// - capture unit uses top pin only with remap clear in MCU mode.
// - smallest package: bits 7 and 6 of first port read zero.
// - second port has bits 7..1, plus bit 0 on largest package.
// - second port direction 1 floats driver, 0 drives latch, or comparator 2/1 output on pins 1/2 while comparator on.
// - second port latch register reads back latched value.
// - second port pins are Schmitt inputs, each independently directed.
// - second port pins 1..6 follow comparator control; off for digital.
// - after reset second port pins 0..6 analog and read zero.
package dgpio_pkg;
  localparam int          DGPIO_AW       = 4;
  localparam int          DGPIO_DW       = 8;
  localparam logic [3:0]  ADR_E_PIN      = 4'h0;
  localparam logic [3:0]  ADR_E_LAT      = 4'h1;
  localparam logic [3:0]  ADR_E_DIR      = 4'h2;
  localparam logic [3:0]  ADR_A_LAT      = 4'h3;
  localparam logic [3:0]  ADR_F_PIN      = 4'h4;
  localparam logic [3:0]  ADR_F_LAT      = 4'h5;
  localparam logic [3:0]  ADR_F_DIR      = 4'h6;
  localparam logic [3:0]  ADR_CMP_CTRL   = 4'h7;
  localparam logic [3:0]  ADR_ANA_CFG    = 4'h8;
  localparam logic [7:0]  RST_LAT        = 8'h00;
  localparam logic [7:0]  RST_DIR        = 8'hFF;
  localparam logic [7:0]  RST_A_LAT      = 8'h00;
  localparam logic [7:0]  RST_CMP_CTRL   = 8'h00;
  localparam logic [7:0]  RST_ANA_CFG    = 8'h00;
  localparam logic [2:0]  CMP_OFF_CODE   = 3'h7;
  localparam logic [3:0]  ANA_DIGITAL    = 4'hF;
  localparam int          A_E_PU_BIT     = 6;
  localparam int          A_D_PU_BIT     = 7;
  localparam int          E_LO_PIN       = 5;
  localparam int          E_NPINS        = 3;
  localparam logic [1:0]  PKG_64         = 2'h0;
  localparam logic [1:0]  PKG_80         = 2'h1;
  localparam logic [1:0]  PKG_100        = 2'h2;
  localparam logic [7:0]  E_MASK_SMALL   = 8'h3F;
  localparam logic [7:0]  F_MASK_SMALL   = 8'hFE;
  localparam logic [7:0]  MASK_ALL       = 8'hFF;
  localparam logic [7:0]  F_CMP_PINS     = 8'h7E;
  localparam int          F_C2OUT_PIN    = 1;
  localparam int          F_C1OUT_PIN    = 2;
endpackage : dgpio_pkg

//--- design/dgpio_top.sv
// first port upper pins and second port with register access
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ns
module dgpio_top
  import dgpio_pkg::*;
#(
  parameter logic [1:0] PKG_SEL = PKG_100
)(
  input  wire logic                MCLK_I,
  input  wire logic                RESETN_I,
  input  wire logic [DGPIO_AW-1:0] ADDR_I,
  input  wire logic [DGPIO_DW-1:0] WDATA_I,
  input  wire logic                WR_I,
  input  wire logic                RD_I,
  output logic      [DGPIO_DW-1:0] RDATA_O,
  input  wire logic                PWM_REMAP_CFG_I,
  input  wire logic                COMPARE_REMAP_CFG_I,
  input  wire logic                MCU_MODE_I,
  input  wire logic                EXT_BUS_EN_I,
  input  wire logic [E_NPINS-1:0]  EXT_BUS_AD_I,
  input  wire logic                EXT_BUS_AD_OE_I,
  output logic      [E_NPINS-1:0]  EXT_BUS_AD_O,
  input  wire logic                PWM1_CHANNEL_B_I,
  input  wire logic                PWM1_CHANNEL_C_I,
  input  wire logic                PWM1_SHUTDOWN_TRI_I,
  input  wire logic                CCP2_OUT_EN_I,
  input  wire logic                CCP2_OUT_I,
  input  wire logic                PWM2_SHUTDOWN_TRI_I,
  output logic                     CCP2_CAPTURE_O,
  input  wire logic                CMP1_OUT_I,
  input  wire logic                CMP2_OUT_I,
  output logic      [2:0]          CMP_MODE_O,
  output logic      [3:0]          ANA_CFG_O,
  input  wire logic [E_NPINS-1:0]  E_PIN_I,
  output logic      [E_NPINS-1:0]  E_PIN_O,
  output logic      [E_NPINS-1:0]  E_PIN_OE_O,
  output logic      [E_NPINS-1:0]  E_PULLUP_O,
  output logic                     D_PULLUP_EN_O,
  input  wire logic [7:0]          F_PIN_I,
  output logic      [7:0]          F_PIN_O,
  output logic      [7:0]          F_PIN_OE_O
);

  function automatic logic [7:0] f_impl_mask(input logic is_e);
    logic [7:0] m;
    m = MASK_ALL;
    if (is_e && PKG_SEL == PKG_64)
      m = E_MASK_SMALL;
    if (!is_e && PKG_SEL != PKG_100)
      m = F_MASK_SMALL;
    return m;
  endfunction : f_impl_mask

  logic [7:0] e_lat_q, e_dir_q, a_lat_q;
  logic [7:0] f_lat_q, f_dir_q, cmp_ctrl_q, ana_cfg_q;
  logic [7:0] f_meta_q, f_sync_q;
  logic [E_NPINS-1:0] e_meta_q, e_sync_q;
  logic [7:0] rdata_d;
  logic [E_NPINS-1:0] e_out_d, e_oe_d, e_pu_d;
  logic [7:0] f_out_d, f_oe_d;

  wire logic [7:0] e_mask   = f_impl_mask(1'b1);
  wire logic [7:0] f_mask   = f_impl_mask(1'b0);
  wire logic       ext_on   = EXT_BUS_EN_I && (PKG_SEL == PKG_100);
  wire logic       pwm1_rt  = PWM_REMAP_CFG_I && (PKG_SEL != PKG_64);
  wire logic       ccp2_rt  = !COMPARE_REMAP_CFG_I && MCU_MODE_I
                              && (PKG_SEL != PKG_64);
  wire logic       cmp_on   = cmp_ctrl_q[2:0] != CMP_OFF_CODE;
  wire logic       ana_on   = ana_cfg_q[3:0] != ANA_DIGITAL;
  wire logic       e_pu_on  = a_lat_q[A_E_PU_BIT];

  wire logic wr_e_pin = WR_I && ADDR_I == ADR_E_PIN;
  wire logic wr_e_lat = WR_I && ADDR_I == ADR_E_LAT;
  wire logic wr_e_dir = WR_I && ADDR_I == ADR_E_DIR;
  wire logic wr_a_lat = WR_I && ADDR_I == ADR_A_LAT;
  wire logic wr_f_pin = WR_I && ADDR_I == ADR_F_PIN;
  wire logic wr_f_lat = WR_I && ADDR_I == ADR_F_LAT;
  wire logic wr_f_dir = WR_I && ADDR_I == ADR_F_DIR;
  wire logic wr_cmp   = WR_I && ADDR_I == ADR_CMP_CTRL;
  wire logic wr_ana   = WR_I && ADDR_I == ADR_ANA_CFG;

  // analog pins of the second port read as zero
  // analog at reset
  wire logic [7:0] f_ana_mask =
    (cmp_on || ana_on ? F_CMP_PINS : 8'h00) |
    (ana_on ? ~F_CMP_PINS & ~8'h80 : 8'h00);

  wire logic [7:0] e_pin_val;
  assign e_pin_val = {e_sync_q, 5'h00} & e_mask;

  wire logic [7:0] f_pin_val;
  assign f_pin_val = f_sync_q & ~f_ana_mask & f_mask;

  always_comb
  begin
    rdata_d = 8'h00;
    case (ADDR_I)
      ADR_E_PIN:    rdata_d = e_pin_val;
      ADR_E_LAT:    rdata_d = e_lat_q & e_mask;
      ADR_E_DIR:    rdata_d = e_dir_q & e_mask;
      ADR_A_LAT:    rdata_d = a_lat_q;
      ADR_F_PIN:    rdata_d = f_pin_val;
      ADR_F_LAT:    rdata_d = f_lat_q & f_mask;
      ADR_F_DIR:    rdata_d = f_dir_q & f_mask;
      ADR_CMP_CTRL: rdata_d = cmp_ctrl_q;
      ADR_ANA_CFG:  rdata_d = ana_cfg_q;
      default:      rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RESETN_I)
      RDATA_O <= 8'h00;
    else if (RD_I)
      RDATA_O <= rdata_d;
    else
      RDATA_O <= 8'h00;
  end

  // register writes; pin register writes land in the latch
  always_ff @(posedge MCLK_I)
  begin
    if (!RESETN_I)
    begin
      e_lat_q    <= RST_LAT;
      e_dir_q    <= RST_DIR;
      a_lat_q    <= RST_A_LAT;
      f_lat_q    <= RST_LAT;
      f_dir_q    <= RST_DIR;
      cmp_ctrl_q <= RST_CMP_CTRL;
      ana_cfg_q  <= RST_ANA_CFG;
    end
    else
    begin
      if (wr_e_pin || wr_e_lat)
        e_lat_q <= WDATA_I & e_mask;
      if (wr_e_dir)
        e_dir_q <= WDATA_I & e_mask;
      if (wr_a_lat)
        a_lat_q <= WDATA_I;
      if (wr_f_pin || wr_f_lat)
        f_lat_q <= WDATA_I & f_mask;
      if (wr_f_dir)
        f_dir_q <= WDATA_I & f_mask;
      if (wr_cmp)
        cmp_ctrl_q <= WDATA_I;
      if (wr_ana)
        ana_cfg_q <= WDATA_I;
    end
  end

  // two-stage synchronizers for pin levels
  always_ff @(posedge MCLK_I)
  begin
    if (!RESETN_I)
    begin
      e_meta_q <= '0;
      e_sync_q <= '0;
      f_meta_q <= 8'h00;
      f_sync_q <= 8'h00;
    end
    else
    begin
      e_meta_q <= E_PIN_I;
      e_sync_q <= e_meta_q;
      f_meta_q <= F_PIN_I;
      f_sync_q <= f_meta_q;
    end
  end

  // first port pin multiplexing
  genvar gi;
  generate
    for (gi = 0; gi < E_NPINS; gi++)
    begin : g_e_pin
      localparam int P = E_LO_PIN + gi;
      wire logic dir  = e_dir_q[P];
      wire logic impl = e_mask[P];
      wire logic pwm1 = (P == E_LO_PIN || P == E_LO_PIN + 1) && pwm1_rt;
      wire logic ccp2 = (P == E_LO_PIN + 2) && ccp2_rt;
      wire logic pwmv = (P == E_LO_PIN) ? PWM1_CHANNEL_C_I
                                        : PWM1_CHANNEL_B_I;
      always_comb
      begin
        e_out_d[gi] = e_lat_q[P];
        e_oe_d[gi]  = !dir;
        e_pu_d[gi]  = dir && e_pu_on;
        if (ext_on)
        begin
          e_out_d[gi] = EXT_BUS_AD_I[gi];
          e_oe_d[gi]  = EXT_BUS_AD_OE_I;
          e_pu_d[gi]  = 1'b0;
        end
        else if (pwm1 && !dir)
        begin
          e_out_d[gi] = pwmv;
          e_oe_d[gi]  = !PWM1_SHUTDOWN_TRI_I;
        end
        else if (ccp2 && !dir && CCP2_OUT_EN_I)
        begin
          e_out_d[gi] = CCP2_OUT_I;
          e_oe_d[gi]  = !PWM2_SHUTDOWN_TRI_I;
        end
        if (!impl)
        begin
          e_out_d[gi] = 1'b0;
          e_oe_d[gi]  = 1'b0;
          e_pu_d[gi]  = 1'b0;
        end
      end
    end
  endgenerate

  // second port drivers
  genvar fi;
  generate
    for (fi = 0; fi < 8; fi++)
    begin : g_f_pin
      always_comb
      begin
        f_out_d[fi] = f_lat_q[fi];
        f_oe_d[fi]  = !f_dir_q[fi] && f_mask[fi];
        if (cmp_on && !f_dir_q[fi] && fi == F_C2OUT_PIN)
          f_out_d[fi] = CMP2_OUT_I;
        if (cmp_on && !f_dir_q[fi] && fi == F_C1OUT_PIN)
          f_out_d[fi] = CMP1_OUT_I;
      end
    end
  endgenerate

  // registered pin outputs
  always_ff @(posedge MCLK_I)
  begin
    if (!RESETN_I)
    begin
      E_PIN_O        <= '0;
      E_PIN_OE_O     <= '0;
      E_PULLUP_O     <= '0;
      F_PIN_O        <= 8'h00;
      F_PIN_OE_O     <= 8'h00;
      EXT_BUS_AD_O   <= '0;
      CCP2_CAPTURE_O <= 1'b0;
      D_PULLUP_EN_O  <= 1'b0;
      CMP_MODE_O     <= 3'h0;
      ANA_CFG_O      <= 4'h0;
    end
    else
    begin
      E_PIN_O        <= e_out_d;
      E_PIN_OE_O     <= e_oe_d;
      E_PULLUP_O     <= e_pu_d;
      F_PIN_O        <= f_out_d;
      F_PIN_OE_O     <= f_oe_d;
      EXT_BUS_AD_O   <= ext_on ? e_sync_q : '0;
      CCP2_CAPTURE_O <= ccp2_rt && !ext_on && e_dir_q[E_LO_PIN + 2]
                        && e_mask[E_LO_PIN + 2] && e_sync_q[2];
      D_PULLUP_EN_O  <= a_lat_q[A_D_PU_BIT];
      CMP_MODE_O     <= cmp_ctrl_q[2:0];
      ANA_CFG_O      <= ana_cfg_q[3:0];
    end
  end

endmodule : dgpio_top

//--- sim/dgpio_properties.sv
// port checks for the dual pin multiplexer
`timescale 1ns/1ns
module dgpio_props
  import dgpio_pkg::*;
(
  input wire logic                MCLK_I,
  input wire logic                RESETN_I,
  input wire logic [DGPIO_AW-1:0] ADDR_I,
  input wire logic [DGPIO_DW-1:0] WDATA_I,
  input wire logic                WR_I,
  input wire logic                RD_I,
  input wire logic [DGPIO_DW-1:0] RDATA_O,
  input wire logic                PWM_REMAP_CFG_I,
  input wire logic                PWM1_CHANNEL_C_I,
  input wire logic                PWM1_SHUTDOWN_TRI_I,
  input wire logic                EXT_BUS_EN_I,
  input wire logic [E_NPINS-1:0]  EXT_BUS_AD_I,
  input wire logic                EXT_BUS_AD_OE_I,
  input wire logic [E_NPINS-1:0]  EXT_BUS_AD_O,
  input wire logic                CCP2_CAPTURE_O,
  input wire logic [2:0]          CMP_MODE_O,
  input wire logic [E_NPINS-1:0]  E_PIN_O,
  input wire logic [E_NPINS-1:0]  E_PIN_OE_O,
  input wire logic [E_NPINS-1:0]  E_PULLUP_O,
  input wire logic [7:0]          F_PIN_OE_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RESETN_I);
  lat_back_a: assert property (WR_I && ADDR_I == ADR_F_LAT ##1
    RD_I && ADDR_I == ADR_F_LAT |=> RDATA_O == $past(WDATA_I, 2))
    else $error("latch read back wrong");
  f_dir_a: assert property (WR_I && ADDR_I == ADR_F_DIR ##1
    !(WR_I && ADDR_I == ADR_F_DIR) |=> F_PIN_OE_O == ~$past(WDATA_I, 2))
    else $error("second port enable wrong");
  cmp_mode_a: assert property (WR_I && ADDR_I == ADR_CMP_CTRL ##1
    !(WR_I && ADDR_I == ADR_CMP_CTRL) |=>
    CMP_MODE_O == $past(WDATA_I[2:0], 2))
    else $error("comparator mode wrong");
  bus_drive_a: assert property ($past(EXT_BUS_EN_I && EXT_BUS_AD_OE_I)
    |-> E_PIN_OE_O == 3'h7 && E_PIN_O == $past(EXT_BUS_AD_I))
    else $error("bus drive wrong");
  bus_float_a: assert property ($past(EXT_BUS_EN_I && !EXT_BUS_AD_OE_I)
    |-> E_PIN_OE_O == 3'h0)
    else $error("bus sample not floating");
  bus_off_a: assert property (!$past(EXT_BUS_EN_I)
    |-> EXT_BUS_AD_O == 3'h0)
    else $error("bus data without bus");
  bus_prio_a: assert property ($past(EXT_BUS_EN_I)
    |-> E_PULLUP_O == 3'h0 && !CCP2_CAPTURE_O)
    else $error("bus not overriding");
  pull_in_a: assert property ((E_PULLUP_O & E_PIN_OE_O) == 3'h0)
    else $error("pull-up on output pin");
  pwm_tri_a: assert property ($past(PWM_REMAP_CFG_I &&
    PWM1_SHUTDOWN_TRI_I && !EXT_BUS_EN_I) |-> E_PIN_OE_O[1:0] == 2'h0)
    else $error("pwm shutdown not floating");
  pwm_drive_a: assert property ($past(PWM_REMAP_CFG_I &&
    !PWM1_SHUTDOWN_TRI_I && !EXT_BUS_EN_I) && E_PIN_OE_O[0] |->
    E_PIN_O[0] == $past(PWM1_CHANNEL_C_I))
    else $error("pwm channel not routed");
endmodule : dgpio_props
bind dgpio_top dgpio_props u_props (.MCLK_I(MCLK_I), .RESETN_I(RESETN_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .PWM_REMAP_CFG_I(PWM_REMAP_CFG_I),
  .PWM1_CHANNEL_C_I(PWM1_CHANNEL_C_I),
  .PWM1_SHUTDOWN_TRI_I(PWM1_SHUTDOWN_TRI_I), .EXT_BUS_EN_I(EXT_BUS_EN_I),
  .EXT_BUS_AD_I(EXT_BUS_AD_I), .EXT_BUS_AD_OE_I(EXT_BUS_AD_OE_I),
  .EXT_BUS_AD_O(EXT_BUS_AD_O), .CCP2_CAPTURE_O(CCP2_CAPTURE_O),
  .CMP_MODE_O(CMP_MODE_O), .E_PIN_O(E_PIN_O), .E_PIN_OE_O(E_PIN_OE_O),
  .E_PULLUP_O(E_PULLUP_O), .F_PIN_OE_O(F_PIN_OE_O));

//--- sim/dgpio_pins.sv
// board side of both ports
`timescale 1ns/1ns
module dgpio_pins (
  input  wire logic       clk_i,
  input  wire logic [2:0] e_o_i,
  input  wire logic [2:0] e_oe_i,
  input  wire logic [2:0] e_pu_i,
  input  wire logic [2:0] e_drv_i,
  input  wire logic [2:0] e_den_i,
  input  wire logic [7:0] f_o_i,
  input  wire logic [7:0] f_oe_i,
  input  wire logic [7:0] f_drv_i,
  input  wire logic [7:0] f_den_i,
  output logic      [2:0] e_pin_o,
  output logic      [7:0] f_pin_o
);
  logic [7:0] tog_q = 8'h00;
  always @(posedge clk_i) tog_q <= ~tog_q;
  assign e_pin_o = (e_oe_i & e_o_i) | (~e_oe_i & e_den_i & e_drv_i) |
                   (~e_oe_i & ~e_den_i & (e_pu_i | tog_q[2:0]));
  assign f_pin_o = (f_oe_i & f_o_i) | (~f_oe_i & f_den_i & f_drv_i) |
                   (~f_oe_i & ~f_den_i & tog_q);
endmodule : dgpio_pins

//--- sim/testbench.sv
// self-checking bench for the pin multiplexer
`timescale 1ns/1ns
module testbench;
  import dgpio_pkg::*;
  logic       clk = 0, rst_n = 0, wr = 0, rd = 0, rd_d = 0;
  logic [3:0] adr = 0, acfg;
  logic [7:0] wd = 0, rdat, f_o, f_oe, f_pin, f_drv = 8'hFF, f_den = 8'hFF;
  logic [7:0] r, d, l;
  logic [2:0] e_o, e_oe, e_pu, e_pin, e_drv = 3'h5, e_den = 3'h7;
  logic [2:0] ad = 0, ad_o, cmode;
  logic       pr = 0, cr = 1, mcu = 0, ben = 0, boe = 0, pb = 0, pc = 0;
  logic       ps = 0, cen = 0, co = 0, c1 = 1, c2 = 0, cap, dpu;
  logic [7:0] expq[$];
  int         bad_count = 0, check_count = 0;
  always #10 clk = ~clk;
  dgpio_top DUT (.MCLK_I(clk), .RESETN_I(rst_n), .ADDR_I(adr),
    .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdat),
    .PWM_REMAP_CFG_I(pr), .COMPARE_REMAP_CFG_I(cr), .MCU_MODE_I(mcu),
    .EXT_BUS_EN_I(ben), .EXT_BUS_AD_I(ad), .EXT_BUS_AD_OE_I(boe),
    .EXT_BUS_AD_O(ad_o), .PWM1_CHANNEL_B_I(pb), .PWM1_CHANNEL_C_I(pc),
    .PWM1_SHUTDOWN_TRI_I(ps), .CCP2_OUT_EN_I(cen), .CCP2_OUT_I(co),
    .PWM2_SHUTDOWN_TRI_I(1'b0), .CCP2_CAPTURE_O(cap), .CMP1_OUT_I(c1),
    .CMP2_OUT_I(c2), .CMP_MODE_O(cmode), .ANA_CFG_O(acfg),
    .E_PIN_I(e_pin), .E_PIN_O(e_o), .E_PIN_OE_O(e_oe),
    .E_PULLUP_O(e_pu), .D_PULLUP_EN_O(dpu), .F_PIN_I(f_pin),
    .F_PIN_O(f_o), .F_PIN_OE_O(f_oe));
  dgpio_pins u_pins (.clk_i(clk), .e_o_i(e_o), .e_oe_i(e_oe),
    .e_pu_i(e_pu), .e_drv_i(e_drv), .e_den_i(e_den), .f_o_i(f_o),
    .f_oe_i(f_oe), .f_drv_i(f_drv), .f_den_i(f_den), .e_pin_o(e_pin),
    .f_pin_o(f_pin));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bus(logic w, logic s, logic [3:0] a, logic [7:0] v);
    wr <= w;
    rd <= s;
    adr <= a;
    wd <= v;
    @(posedge clk);
  endtask : bus
  task automatic rd_r(logic [3:0] a, logic [7:0] e);
    expq.push_back(e);
    bus(0, 1, a, 8'h00);
  endtask : rd_r
  task automatic settle;
    bus(0, 0, 4'h0, 8'h00);
    repeat (4) @(posedge clk);
  endtask : settle
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk)
    if (rd_d)
    begin
      chk("rdata", expq[0], rdat);
      void'(expq.pop_front());
    end
  initial
  begin
    #200000;
    bad_count++;
    close_out;
  end
  initial
  begin
    r = $urandom(83103);
    repeat (4) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    for (int a = 0; a < 16; a++)
      rd_r(a[3:0], a == 0 ? 8'hA0 : a == 4 ? 8'h80 :
        (a == 2 || a == 6) ? 8'hFF : 8'h00);
    bus(1, 0, ADR_F_DIR, 8'hF9);
    settle;
    chk("cmp_out", 8'h02, {6'h0, f_o[2:1]});
    bus(1, 0, ADR_CMP_CTRL, 8'h07);
    bus(1, 0, ADR_ANA_CFG, 8'h0F);
    f_drv <= r;
    settle;
    chk("modes", 8'h7F, {1'b0, cmode, acfg});
    rd_r(ADR_F_PIN, r & 8'hF9);
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom;
      l = $urandom;
      r = $urandom;
      f_drv <= r;
      bus(1, 0, ADR_F_DIR, d);
      bus(1, 0, ADR_F_LAT, l);
      rd_r(ADR_F_LAT, l);
      settle;
      chk("f_oe", ~d, f_oe);
      chk("f_out", l & ~d, f_o & ~d);
      rd_r(ADR_F_PIN, (l & ~d) | (r & d));
    end
    e_den <= 3'h0;
    bus(1, 0, ADR_E_DIR, 8'h00);
    bus(1, 0, ADR_E_LAT, l);
    rd_r(ADR_E_LAT, l);
    settle;
    chk("e_lat", {5'h0, l[7:5]}, {5'h0, e_o});
    pr <= 1;
    pb <= 1;
    cr <= 0;
    mcu <= 1;
    cen <= 1;
    co <= 1;
    settle;
    chk("e_alt", 8'h06, {5'h0, e_o});
    ps <= 1;
    settle;
    chk("e_tri", 8'h04, {5'h0, e_oe});
    ps <= 0;
    bus(1, 0, ADR_E_DIR, 8'hFF);
    bus(1, 0, ADR_A_LAT, 8'hC0);
    settle;
    chk("pullup", 8'h0F, {4'h0, dpu, e_pu});
    chk("capture", 8'h01, {7'h0, cap});
    rd_r(ADR_E_PIN, 8'hE0);
    ben <= 1;
    boe <= 1;
    ad <= 3'h5;
    settle;
    chk("bus_out", 8'h3D, {2'h0, e_oe, e_o});
    boe <= 0;
    e_den <= 3'h7;
    e_drv <= 3'h3;
    settle;
    chk("bus_in", 8'h03, {5'h0, ad_o});
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    rd_r(ADR_F_PIN, r & 8'h80);
    rd_r(ADR_CMP_CTRL, 8'h00);
    settle;
    close_out;
  end
endmodule : testbench
